// file: core/sdu_consts.svh
// Offsets, field positions, reset values and timing figures of the safety diagnostics unit
`ifndef SDU_CONSTS_SVH
`define SDU_CONSTS_SVH
// Extended read address of the uptime heartbeat counter
`define SDU_ADDR_HEARTBEAT 8'h80
// Field positions in the period setting word and in the shadow common word
`define SDU_CYCLE_TIME_LSB 12
`define SDU_CYCLE_TIME_MSB 17
`define SDU_DST_BIT 13
`define SDU_CSE_BIT 18
`define SDU_LBE_BIT 19
// Reset values
`define SDU_HEARTBEAT_RST 32'h0000_0000
`define SDU_LFSR_SEED 31'h0000_0001
// Timing figures in their own unit, and cycle counts derived from the clock period
`define SDU_CLK_PERIOD_NS 4
`define SDU_HEARTBEAT_STEP_NS 8192000
`define SDU_HEARTBEAT_STEP_CYC (`SDU_HEARTBEAT_STEP_NS / `SDU_CLK_PERIOD_NS)
`define SDU_SELFTEST_NS 30000000
`define SDU_SELFTEST_CYC (`SDU_SELFTEST_NS / `SDU_CLK_PERIOD_NS)
// Transducer test: emulated angle steps, and angle width in bits
`define SDU_XT_STEPS 8
`define SDU_ANGLE_W 12
`define SDU_ANGLE_TOL 12'h020
`endif

// file: core/sdu_pkg.sv
// Types shared by the safety diagnostics unit
package sdu_pkg;
    // Transducer self-test sequencer states
    typedef enum logic [0:0] {XT_IDLE, XT_RUN} sdu_xt_state_t;
    // Logic self-test states
    typedef enum logic [0:0] {LB_IDLE, LB_RUN} sdu_lb_state_t;
endpackage

// file: core/sdu_logic_builtin_selftest.sv
// Logic self-test engine: LFSR stimulus, 31 scan chains, MISR signature check
`timescale 1ns/10ps
`include "sdu_consts.svh"
module sdu_logic_builtin_selftest
    import sdu_pkg::*;
#(
    parameter int CHAINS = 31,
    parameter int RUN_CYC = `SDU_SELFTEST_CYC,
    parameter logic [30:0] SIG_EXP = 31'h1234_5678
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [CHAINS-1:0] scan_out,
    output logic scan_enable,
    output logic [CHAINS-1:0] scan_in,
    output logic busy,
    output logic done,
    output logic fail,
    output logic [CHAINS-1:0] signature
);
    sdu_lb_state_t state_q, state_d;
    logic [CHAINS-1:0] lfsr_q, lfsr_d; // Stimulus generator
    logic [CHAINS-1:0] misr_q, misr_d; // Response compactor
    logic [31:0] cnt_q, cnt_d; // Shift cycles in this run
    logic fail_q, fail_d;
    logic done_q, done_d;
    logic last;

    assign last = cnt_q == 32'(RUN_CYC - 1);

    // Next state; a start while busy is ignored so a run is never cut short
    always_comb
    begin
        state_d = state_q;
        lfsr_d = lfsr_q;
        misr_d = misr_q;
        cnt_d = cnt_q;
        fail_d = fail_q;
        done_d = 1'b0;
        case (state_q)
            LB_IDLE:
            begin
                if (start)
                begin
                    state_d = LB_RUN;
                    lfsr_d = `SDU_LFSR_SEED;
                    misr_d = '0;
                    cnt_d = '0;
                    fail_d = 1'b0;
                end
            end
            default:
            begin
                // Polynomial x^31 + x^28 + 1 feeds every chain in parallel
                lfsr_d = {lfsr_q[CHAINS-2:0], lfsr_q[CHAINS-1] ^ lfsr_q[27]};
                // Every chain output folds into the signature each shift
                misr_d = {misr_q[CHAINS-2:0], misr_q[CHAINS-1] ^ misr_q[27]} ^ scan_out;
                cnt_d = cnt_q + 32'h0000_0001;
                if (last)
                begin
                    state_d = LB_IDLE;
                    done_d = 1'b1;
                    fail_d = misr_d != SIG_EXP;
                end
            end
        endcase
    end

    // Registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= LB_IDLE;
            lfsr_q <= `SDU_LFSR_SEED;
            misr_q <= '0;
            cnt_q <= '0;
            fail_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            lfsr_q <= lfsr_d;
            misr_q <= misr_d;
            cnt_q <= cnt_d;
            fail_q <= fail_d;
            done_q <= done_d;
        end
    end

    // Chains shift on their own, no external scan port is involved
    assign scan_enable = state_q == LB_RUN;
    assign scan_in = lfsr_q;
    assign busy = state_q == LB_RUN;
    assign done = done_q;
    assign fail = fail_q;
    assign signature = misr_q;

    a_lb_done_fail: assert property (@(posedge sys_clk) disable iff (rst)
        done |-> (fail == (misr_q != SIG_EXP))) else $error("signature verdict wrong");
    a_lb_scan_lfsr: assert property (@(posedge sys_clk) disable iff (rst)
        scan_enable ##1 scan_enable |-> scan_in[CHAINS-1:1] == $past(scan_in[CHAINS-2:0]))
        else $error("stimulus not shifting");
endmodule

// file: core/sdu_osc_wdog.sv
// Oscillator watchdog: counts system clock periods across a window of the second oscillator
`timescale 1ns/10ps
module sdu_osc_wdog #(
    parameter int WIN_EDGES = 16,
    parameter int LO_LIM = 64,
    parameter int HI_LIM = 256
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic aux_osc_in,
    input wire logic err_clear,
    output logic err_flag
);
    logic s1_q, s2_q, s3_q; // Synchroniser, then edge history
    logic [15:0] edges_q, edges_d; // Aux rising edges in window
    logic [31:0] per_q, per_d; // System periods in window
    logic err_q, err_d;
    logic rise, win_end, bad;

    assign rise = s2_q & ~s3_q;
    assign win_end = rise && (edges_q == 16'(WIN_EDGES - 1));
    // A stalled aux oscillator trips the upper limit without waiting for an edge
    assign bad = (per_q > 32'(HI_LIM)) || (win_end && (per_q < 32'(LO_LIM)));

    // Window counters; sticky error where a new error beats a clear
    always_comb
    begin
        edges_d = edges_q;
        per_d = per_q + 32'h0000_0001;
        if (win_end || bad)
        begin
            edges_d = '0;
            per_d = '0;
        end
        else if (rise)
        begin
            edges_d = edges_q + 16'h0001;
        end
        err_d = bad | (err_q & ~err_clear);
    end

    // Registers; runs from reset onward with no enable
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            edges_q <= '0;
            per_q <= '0;
            err_q <= 1'b0;
        end
        else
        begin
            s1_q <= aux_osc_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            edges_q <= edges_d;
            per_q <= per_d;
            err_q <= err_d;
        end
    end

    assign err_flag = err_q;

    a_wd_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        bad |=> err_flag) else $error("watchdog error not latched");
    a_wd_bound: assert property (@(posedge sys_clk) disable iff (rst)
        per_q <= 32'(HI_LIM) + 32'h0000_0001) else $error("period count exceeds limit");
endmodule

// file: core/sdu_top.sv
// Safety diagnostics unit: heartbeat counter, watchdog, logic and transducer self-tests
`timescale 1ns/10ps
`include "sdu_consts.svh"
// Function
// - 32-bit heartbeat counter, zero after any reset
// - Increment every (setting plus one) times 8.192 ms
// - Counter wraps to zero, no saturation
// - Extended read at 0x80 returns count
// - Oscillator watchdog runs continuously
// - Count system clock periods per other-oscillator window against limits
// - Logic self-test shifts 31 chains automatically
// - 31-bit LFSR feeds all chains
// - MISR compacts chain outputs to signature
// - Logic and transducer tests run concurrently
// - Logic self-test lasts about 30 ms
// - Transducer switched to test-current configuration
// - Sequencer steps current and elements to rotate
// - Measured angle decides pass or fail
// - Transducer self-test lasts about 30 ms
// - Enable bit runs transducer test at power-up
// - Special command starts transducer test
// - Done flag set at end of commanded run only, running flag cleared after any run
// - Failed transducer test sets failure flag
// - Period setting is word 0x1D bits 17:12
// - Transducer power-up enable is 0x1E bit 18
// - Logic test power-up enable 0x1E bit 19
// - Bit 13 set blocks special start
module sdu_top
    import sdu_pkg::*;
#(
    parameter int TICK_CYC = `SDU_HEARTBEAT_STEP_CYC,
    parameter int XT_RUN_CYC = `SDU_SELFTEST_CYC,
    parameter int LB_RUN_CYC = `SDU_SELFTEST_CYC,
    parameter logic [30:0] LB_SIG_EXP = 31'h1234_5678,
    parameter int WD_WIN_EDGES = 16,
    parameter int WD_LO_LIM = 64,
    parameter int WD_HI_LIM = 256,
    parameter logic [`SDU_ANGLE_W-1:0] ANGLE_TOL = `SDU_ANGLE_TOL
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hard_rst_req,
    input wire logic [23:0] period_config_word,
    input wire logic [23:0] shadow_common_config_word,
    input wire logic rd_req,
    input wire logic [7:0] rd_addr,
    output logic [31:0] rd_data,
    output logic rd_ack,
    input wire logic special_selftest_cmd,
    input wire logic err_clear,
    input wire logic wdog_err_clear,
    output logic special_done_flag,
    output logic transducer_test_running_flag,
    output logic selftest_fail_flag,
    input wire logic [`SDU_ANGLE_W-1:0] angle_in,
    output logic xt_test_config,
    output logic xt_current_dir,
    output logic [1:0] xt_element_sel,
    input wire logic aux_osc_in,
    output logic osc_wdog_err_flag,
    input wire logic [30:0] scan_out,
    output logic scan_enable,
    output logic [30:0] scan_in,
    output logic logic_builtin_selftest_running,
    output logic logic_builtin_selftest_done,
    output logic logic_builtin_selftest_fail_flag
);
    localparam int STEP_CYC = XT_RUN_CYC / `SDU_XT_STEPS; // Rounds down to keep the run within bound

    // Heartbeat counter state
    logic [31:0] pre_q, pre_d; // Cycles within one 8.192 ms step
    logic [5:0] per_q, per_d; // Steps within one increment period
    logic [31:0] beat_q, beat_d; // The uptime heartbeat count
    logic [5:0] cycle_time; // Period setting from the nonvolatile word
    logic tick, beat_inc;

    // Register read port state
    logic [31:0] rd_data_q, rd_data_d;
    logic rd_ack_q, rd_ack_d;

    // Transducer self-test state
    sdu_xt_state_t xt_q, xt_d;
    logic [2:0] step_q, step_d; // Emulated angle step
    logic [31:0] stc_q, stc_d; // Cycles in current step
    logic xfail_q, xfail_d; // Any step out of tolerance
    logic by_cmd_q, by_cmd_d; // Run was started by the special command
    logic sdn_q, sdn_d;
    logic stf_q, stf_d;
    logic pu_q, pu_d; // Power-up window, one cycle after release
    logic xt_start, xt_end, step_end, step_bad, cmd_ok;
    logic [`SDU_ANGLE_W-1:0] exp_angle, angle_diff;

    // Logic self-test start
    logic lb_start;

    assign cycle_time = period_config_word[`SDU_CYCLE_TIME_MSB:`SDU_CYCLE_TIME_LSB];
    assign tick = pre_q == 32'(TICK_CYC - 1);
    assign beat_inc = tick && (per_q >= cycle_time);

    // Heartbeat next values; hard reset restarts everything from zero
    always_comb
    begin
        pre_d = tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
        per_d = per_q;
        beat_d = beat_q;
        if (tick)
        begin
            per_d = beat_inc ? 6'h00 : per_q + 6'h01;
        end
        if (beat_inc)
        begin
            // Natural 32-bit overflow gives the wrap, no flag is raised
            beat_d = beat_q + 32'h0000_0001;
        end
        if (hard_rst_req)
        begin
            pre_d = '0;
            per_d = '0;
            beat_d = `SDU_HEARTBEAT_RST;
        end
    end

    // Heartbeat registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pre_q <= '0;
            per_q <= '0;
            beat_q <= `SDU_HEARTBEAT_RST;
        end
        else
        begin
            pre_q <= pre_d;
            per_q <= per_d;
            beat_q <= beat_d;
        end
    end

    // Extended read: only the heartbeat address is mapped, others read zero
    always_comb
    begin
        rd_ack_d = rd_req;
        rd_data_d = rd_data_q;
        if (rd_req)
        begin
            if (rd_addr == `SDU_ADDR_HEARTBEAT)
            begin
                rd_data_d = beat_q;
            end
            else
            begin
                rd_data_d = '0;
            end
        end
    end

    // Read port registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_q <= '0;
            rd_ack_q <= 1'b0;
        end
        else
        begin
            rd_data_q <= rd_data_d;
            rd_ack_q <= rd_ack_d;
        end
    end

    // Special command is honoured only while the disable bit is clear
    assign cmd_ok = special_selftest_cmd && !shadow_common_config_word[`SDU_DST_BIT];
    assign xt_start = (xt_q == XT_IDLE) &&
        ((pu_q && shadow_common_config_word[`SDU_CSE_BIT]) || cmd_ok);
    assign step_end = (xt_q == XT_RUN) && (stc_q == 32'(STEP_CYC - 1));
    assign xt_end = step_end && (step_q == 3'(`SDU_XT_STEPS - 1));
    // Each step emulates 45 degrees; the wrap-around difference tolerates noise either side
    assign exp_angle = {step_q, 9'h000};
    assign angle_diff = angle_in - exp_angle;
    assign step_bad = (angle_diff > ANGLE_TOL) && (angle_diff < (~ANGLE_TOL + 12'h001));

    // Transducer sequencer next values
    always_comb
    begin
        xt_d = xt_q;
        step_d = step_q;
        stc_d = stc_q;
        xfail_d = xfail_q;
        by_cmd_d = by_cmd_q;
        sdn_d = sdn_q;
        pu_d = 1'b0;
        case (xt_q)
            XT_IDLE:
            begin
                if (xt_start)
                begin
                    xt_d = XT_RUN;
                    step_d = '0;
                    stc_d = '0;
                    xfail_d = 1'b0;
                    by_cmd_d = cmd_ok;
                    sdn_d = 1'b0;
                end
            end
            default:
            begin
                stc_d = step_end ? 32'h0000_0000 : stc_q + 32'h0000_0001;
                if (step_end)
                begin
                    step_d = step_q + 3'h1;
                    xfail_d = xfail_q | step_bad;
                end
                if (xt_end)
                begin
                    xt_d = XT_IDLE;
                    sdn_d = by_cmd_q;
                end
            end
        endcase
        // A failure landing on the clear cycle still sets the flag
        stf_d = (stf_q & ~err_clear) | (xt_end & (xfail_q | step_bad));
    end

    // Transducer sequencer registers; pu_q resets high to mark power-up
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            xt_q <= XT_IDLE;
            step_q <= '0;
            stc_q <= '0;
            xfail_q <= 1'b0;
            by_cmd_q <= 1'b0;
            sdn_q <= 1'b0;
            stf_q <= 1'b0;
            pu_q <= 1'b1;
        end
        else
        begin
            xt_q <= xt_d;
            step_q <= step_d;
            stc_q <= stc_d;
            xfail_q <= xfail_d;
            by_cmd_q <= by_cmd_d;
            sdn_q <= sdn_d;
            stf_q <= stf_d;
            pu_q <= pu_d;
        end
    end

    // Logic test at power-up only; it shares only the power-up window pu_q with the transducer test
    assign lb_start = pu_q && shadow_common_config_word[`SDU_LBE_BIT];

    // Logic self-test engine
    sdu_logic_builtin_selftest #(
        .CHAINS(31),
        .RUN_CYC(LB_RUN_CYC),
        .SIG_EXP(LB_SIG_EXP)
    ) u_logic_builtin_selftest (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(lb_start),
        .scan_out(scan_out),
        .scan_enable(scan_enable),
        .scan_in(scan_in),
        .busy(logic_builtin_selftest_running),
        .done(logic_builtin_selftest_done),
        .fail(logic_builtin_selftest_fail_flag),
        .signature()
    );

    // Oscillator watchdog
    sdu_osc_wdog #(
        .WIN_EDGES(WD_WIN_EDGES),
        .LO_LIM(WD_LO_LIM),
        .HI_LIM(WD_HI_LIM)
    ) u_wdog (
        .sys_clk(sys_clk),
        .rst(rst),
        .aux_osc_in(aux_osc_in),
        .err_clear(wdog_err_clear),
        .err_flag(osc_wdog_err_flag)
    );

    assign rd_data = rd_data_q;
    assign rd_ack = rd_ack_q;
    assign special_done_flag = sdn_q;
    assign transducer_test_running_flag = xt_q == XT_RUN;
    assign selftest_fail_flag = stf_q;
    assign xt_test_config = xt_q == XT_RUN;
    assign xt_current_dir = step_q[2];
    assign xt_element_sel = step_q[1:0];

    a_beat_step: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(hard_rst_req) && !$past(beat_inc) |-> $stable(beat_q)) else $error("count moved off period");
    a_beat_inc: assert property (@(posedge sys_clk) disable iff (rst)
        beat_inc && !hard_rst_req |=> beat_q == $past(beat_q) + 32'h0000_0001) else $error("count not +1");
    a_beat_hrst: assert property (@(posedge sys_clk) disable iff (rst)
        hard_rst_req |=> beat_q == 32'h0000_0000) else $error("hard reset not cleared");
    a_read_alive: assert property (@(posedge sys_clk) disable iff (rst)
        rd_req && rd_addr == 8'h80 |=> rd_ack && rd_data == $past(beat_q)) else $error("bad heartbeat read");
    a_cmd_blocked: assert property (@(posedge sys_clk) disable iff (rst)
        !pu_q && special_selftest_cmd && shadow_common_config_word[13] && xt_q == XT_IDLE |=> xt_q == XT_IDLE)
        else $error("disabled command started test");
    a_done_flags: assert property (@(posedge sys_clk) disable iff (rst)
        xt_end && by_cmd_q |=> special_done_flag && !transducer_test_running_flag)
        else $error("completion not signalled");
    a_fail_sets: assert property (@(posedge sys_clk) disable iff (rst)
        xt_end && step_bad |=> selftest_fail_flag) else $error("failure not flagged");
    a_test_config: assert property (@(posedge sys_clk) disable iff (rst)
        cmd_ok && xt_q == XT_IDLE |=> xt_test_config [*2]) else $error("test configuration missing");
endmodule

// file: dv/sdu_far_model.sv
// Far-side model: transducer front end, one-flop scan chains and the second oscillator
`timescale 1ns/10ps
`include "sdu_consts.svh"
module sdu_far_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic xt_test_config,
    input wire logic xt_current_dir,
    input wire logic [1:0] xt_element_sel,
    input wire logic angle_bad,
    input wire logic aux_stop,
    input wire logic [30:0] scan_in,
    output logic [`SDU_ANGLE_W-1:0] angle_in,
    output logic aux_osc_in,
    output logic [30:0] scan_out
);
    // Changing pattern while no test current flows, so a stale angle never looks valid
    logic [`SDU_ANGLE_W-1:0] junk_q;

    // One flop per chain: every chain really shifts and feeds the compactor
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            scan_out <= 31'h0000_0000;
            junk_q <= 12'h5a5;
        end
        else
        begin
            scan_out <= scan_in;
            junk_q <= ~junk_q + 12'h001;
        end
    end

    // Current direction and element pick a 45 degree step; a fault skews it past tolerance
    always_comb
    begin
        if (xt_test_config)
            angle_in = {xt_current_dir, xt_element_sel, 9'h000} + (angle_bad ? 12'h100 : 12'h000);
        else
            angle_in = junk_q;
    end

    // Second oscillator, 30 ns period, unrelated to the system clock; a dead one holds its level
    // One process drives the oscillator so it has a single driver
    initial
    begin
        aux_osc_in = 1'b0;
        forever
        begin
            #15;
            aux_osc_in = aux_stop ? aux_osc_in : ~aux_osc_in;
        end
    end
endmodule

// file: dv/test_safety_diagnostics_unit.sv
// Testbench: reads, self-test commands and fault cases of the safety diagnostics unit
`timescale 1ns/10ps
module test_safety_diagnostics_unit;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hard_rst_req = 1'b0;
    logic [23:0] period_config_word = 24'h00_0000;
    // Both power-up tests enabled at start
    logic [23:0] shadow_common_config_word = 24'h0c_0000;
    logic rd_req = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [31:0] rd_data;
    logic rd_ack;
    logic special_selftest_cmd = 1'b0;
    logic err_clear = 1'b0;
    logic wdog_err_clear = 1'b0;
    logic special_done_flag, transducer_test_running_flag, selftest_fail_flag;
    logic [11:0] angle_in;
    logic xt_test_config, xt_current_dir;
    logic [1:0] xt_element_sel;
    logic aux_osc_in, osc_wdog_err_flag;
    logic [30:0] scan_out, scan_in;
    logic scan_enable, logic_builtin_selftest_running, logic_builtin_selftest_done, logic_builtin_selftest_fail_flag;
    // Fault knobs of the far-side model
    logic angle_bad = 1'b0;
    logic aux_stop = 1'b0;
    // Period settings tried for the heartbeat
    logic [5:0] ct_tab [2] = '{6'h00, 6'h05};
    int mismatches = 0;
    int checks = 0;
    int p;
    int n;

    // 250 MHz system clock
    always #2 sys_clk = ~sys_clk;

    // Long counts shortened so the run stays brief
    sdu_top #(.TICK_CYC(4), .XT_RUN_CYC(64), .LB_RUN_CYC(40)) dut (
        .sys_clk, .rst, .hard_rst_req, .period_config_word, .shadow_common_config_word,
        .rd_req, .rd_addr, .rd_data, .rd_ack, .special_selftest_cmd, .err_clear, .wdog_err_clear,
        .special_done_flag, .transducer_test_running_flag, .selftest_fail_flag, .angle_in,
        .xt_test_config, .xt_current_dir, .xt_element_sel, .aux_osc_in, .osc_wdog_err_flag,
        .scan_out, .scan_enable, .scan_in, .logic_builtin_selftest_running, .logic_builtin_selftest_done, .logic_builtin_selftest_fail_flag
    );

    sdu_far_model far (
        .sys_clk, .rst, .xt_test_config, .xt_current_dir, .xt_element_sel, .angle_bad,
        .aux_stop, .scan_in, .angle_in, .aux_osc_in, .scan_out
    );

    // Inputs always move 1 ns after the rising edge
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Request is taken at the next edge; acknowledge and data stand for the cycle after it
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_req = 1'b1;
        rd_addr = a;
        tick();
        chk({31'h0, rd_ack}, 32'h1);
        chk(rd_data, exp);
        rd_req = 1'b0;
    endtask

    // One-cycle strobe: 0 hard reset, 1 special start, 2 failure clear, 3 watchdog clear
    task automatic pulse(input int s);
        {hard_rst_req, special_selftest_cmd, err_clear, wdog_err_clear} = 4'h8 >> s;
        tick();
        {hard_rst_req, special_selftest_cmd, err_clear, wdog_err_clear} = 4'h0;
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: pick = transducer_test_running_flag;
            1: pick = logic_builtin_selftest_done;
            default: pick = osc_wdog_err_flag;
        endcase
    endfunction

    // Bounded wait; running out of patience ends the run
    task automatic wait_on(input int s, input logic v, input int lim);
        n = 0;
        while (pick(s) !== v && n < lim)
        begin
            tick();
            n++;
        end
        if (n >= lim)
        begin
            mismatches++;
            $display("Error %0t: wait timed out", $time);
            summarize();
        end
    endtask

    // Commanded transducer test; a second start mid-run must be ignored
    task automatic run_xt(input logic bad);
        angle_bad = bad;
        pulse(2);
        pulse(1);
        chk({28'h0, transducer_test_running_flag, xt_test_config, special_done_flag, selftest_fail_flag}, 32'hc);
        n = 0;
        while (transducer_test_running_flag === 1'b1 && n < 200)
        begin
            special_selftest_cmd = (n == 10);
            tick();
            n++;
        end
        if (n >= 200)
        begin
            mismatches++;
            $display("Error %0t: transducer test never ended", $time);
            summarize();
        end
        chk({31'h0, n >= 63 && n <= 65}, 32'h1);
        chk({29'h0, xt_test_config, special_done_flag, selftest_fail_flag}, {30'h0, 1'b1, bad});
    endtask

    initial
    begin
        repeat (4) @(posedge sys_clk);
        #1;
        // Values while reset is held
        chk({28'h0, special_done_flag, transducer_test_running_flag, selftest_fail_flag, osc_wdog_err_flag}, 32'h0);
        chk(rd_data, 32'h0);
        chk({1'b0, scan_in}, 32'h1);
        rst = 1'b0;
        tick();
        tick();
        // Both power-up tests run side by side
        chk({28'h0, xt_test_config, transducer_test_running_flag, logic_builtin_selftest_running, scan_enable}, 32'hf);
        wait_on(1, 1'b1, 60);
        chk({30'h0, logic_builtin_selftest_fail_flag, transducer_test_running_flag}, 32'h3);
        wait_on(0, 1'b0, 200);
        chk({29'h0, special_done_flag, selftest_fail_flag, scan_enable}, 32'h0);
        // Heartbeat rate for two period settings, counted from a hard reset
        foreach (ct_tab[i])
        begin
            period_config_word = {6'h00, ct_tab[i], 12'h000};
            p = (ct_tab[i] + 1) * 4;
            pulse(0);
            repeat (p / 2) tick();
            rd(8'h80, 32'h0);
            repeat (3 * p - 2) tick();
            rd(8'h80, 32'h3);
        end
        rd(8'h44, 32'h0);
        // Special start blocked by the disable bit
        shadow_common_config_word = 24'h00_2000;
        pulse(1);
        tick();
        chk({30'h0, transducer_test_running_flag, special_done_flag}, 32'h0);
        shadow_common_config_word = 24'h00_0000;
        run_xt(1'b0);
        run_xt(1'b1);
        pulse(2);
        chk({31'h0, selftest_fail_flag}, 32'h0);
        // Watchdog: healthy, dead oscillator, sticky until cleared
        pulse(3);
        repeat (300) tick();
        chk({31'h0, osc_wdog_err_flag}, 32'h0);
        aux_stop = 1'b1;
        wait_on(2, 1'b1, 400);
        aux_stop = 1'b0;
        repeat (300) tick();
        chk({31'h0, osc_wdog_err_flag}, 32'h1);
        pulse(3);
        repeat (300) tick();
        chk({31'h0, osc_wdog_err_flag}, 32'h0);
        summarize();
    end
endmodule
